/* File: core/ims_top.sv */
// Two-wire master byte sequencer: repeated start, transmit, receive, acknowledge.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Restart request ignored unless sequencer idle
// - Restart: SCL low, load counter, release SDA
// - Release SCL, reload, both lines high
// - SDA low period, SCL low, clear request
// - Start-seen at once, interrupt after expiry
// - Restart collision: SDA low or SCL falls
// - Idle buffer write starts byte transmission
// - Bits MSB first, low then high period
// - After eighth bit clear full, release SDA
// - Ninth clock SDA stored as ack status
// - After ninth clock interrupt, hold SCL low
// - Busy buffer write sets write collision
// - Receive request honoured only when idle
// - Receive toggles SCL, shifts SDA in
// - Eighth fall: buffer, full, interrupt, idle
// - Full set on receive, cleared by read
// - Overflow when byte completes while full
// - Host transmit flow driven by interrupts
// - Acknowledge: drive value, clock one pulse
// - Counter pauses until SCL sampled high
// - Collision aborts, releases lines, sets flag
module ims_top
  import ims_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ims_state_e  state;
  ims_rate_if  rate ();
  logic        scl_s, sda_s, scl_q, sda_q;
  logic        scl_low, sda_low;
  logic [7:0]  shift_reg, byte_buffer, rate_reload_value;
  logic [3:0]  bit_cnt;
  logic        restart_request, receive_request, ack_sequence_request, ack_value;
  logic        buffer_full, ack_received_status, start_seen, port_irq_flag;
  logic        write_collision, receive_overflow, collision_flag;
  logic        rd_ok, idle, coll_now;
  logic        apb_wr, apb_rd, ctrl_wr, stat_wr, buf_wr, buf_rd, buf_wr_ok;
  logic        rs_done, tx_eighth, tx_done, rx_done, ak_done, start_pattern;
  logic [31:0] next_prdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic is_release(input ims_state_e s);
    return s == IMS_RS_SCL_REL || s == IMS_TX_REL || s == IMS_RX_REL || s == IMS_AK_REL;
  endfunction

  // ----------------------------------------------------------------
  // Line sampling and rate counter
  // ----------------------------------------------------------------
  ims_sync u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .ce_i       (ce_i),
    .async_i    ({scl_i, sda_i}),
    .sync_o     ({scl_s, sda_s})
  );

  ims_rate_ctr u_rate (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .rate       (rate.ctr)
  );

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start_pattern = scl_q && scl_s && sda_q && !sda_s;
  assign scl_o         = 1'b0;
  assign sda_o         = 1'b0;
  assign scl_oe_n_o    = !scl_low;
  assign sda_oe_n_o    = !sda_low;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  assign pready_o  = ce_i && (pwrite_i || rd_ok);
  assign pslverr_o = pready_o && !(hit(paddr_i, IMS_OFS_CTRL) || hit(paddr_i, IMS_OFS_STATUS)
                     || hit(paddr_i, IMS_OFS_BUFFER) || hit(paddr_i, IMS_OFS_RATE));
  assign apb_wr    = psel_i && penable_i && pwrite_i && pready_o;
  assign apb_rd    = psel_i && penable_i && !pwrite_i && pready_o;
  assign ctrl_wr   = apb_wr && hit(paddr_i, IMS_OFS_CTRL);
  assign stat_wr   = apb_wr && hit(paddr_i, IMS_OFS_STATUS);
  assign buf_wr    = apb_wr && hit(paddr_i, IMS_OFS_BUFFER);
  assign buf_rd    = apb_rd && hit(paddr_i, IMS_OFS_BUFFER);
  assign buf_wr_ok = buf_wr && idle;
  // Pending requests count as busy so a request and a write never both start.
  assign idle = (state == IMS_IDLE) && !restart_request && !receive_request
                && !ack_sequence_request;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr_i, IMS_OFS_CTRL)) begin
      next_prdata[IMS_CTRL_RESTART] = restart_request;
      next_prdata[IMS_CTRL_RECEIVE] = receive_request;
      next_prdata[IMS_CTRL_ACKSEQ]  = ack_sequence_request;
      next_prdata[IMS_CTRL_ACKVAL]  = ack_value;
    end else if (hit(paddr_i, IMS_OFS_STATUS)) begin
      next_prdata[IMS_ST_BF]    = buffer_full;
      next_prdata[IMS_ST_ACKRX] = ack_received_status;
      next_prdata[IMS_ST_START] = start_seen;
      next_prdata[IMS_ST_IRQ]   = port_irq_flag;
      next_prdata[IMS_ST_WRITE_COLLISION]  = write_collision;
      next_prdata[IMS_ST_OVF]   = receive_overflow;
      next_prdata[IMS_ST_BCOL]  = collision_flag;
      next_prdata[IMS_ST_IDLE]  = idle;
    end else if (hit(paddr_i, IMS_OFS_BUFFER)) begin
      next_prdata[7:0] = byte_buffer;
    end else if (hit(paddr_i, IMS_OFS_RATE)) begin
      next_prdata[7:0] = rate_reload_value;
    end
  end

  // Read data is captured in the setup cycle, so reads answer with no wait state.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_ok    <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rd_ok    <= psel_i && !pwrite_i && !(penable_i && rd_ok);
      prdata_o <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      restart_request      <= 1'b0;
      receive_request      <= 1'b0;
      ack_sequence_request <= 1'b0;
      ack_value            <= 1'b0;
      rate_reload_value    <= IMS_RATE_RESET;
    end else if (ce_i) begin
      if (apb_wr && hit(paddr_i, IMS_OFS_RATE)) begin
        rate_reload_value <= pwdata_i[7:0];
      end
      if (ctrl_wr) begin
        ack_value <= pwdata_i[IMS_CTRL_ACKVAL];
      end
      if (ctrl_wr && idle) begin
        restart_request      <= pwdata_i[IMS_CTRL_RESTART];
        receive_request      <= pwdata_i[IMS_CTRL_RECEIVE];
        ack_sequence_request <= pwdata_i[IMS_CTRL_ACKSEQ];
      end else begin
        if (rs_done || coll_now) begin
          restart_request <= 1'b0;
        end
        if (rx_done) begin
          receive_request <= 1'b0;
        end
        if (ak_done || coll_now) begin
          ack_sequence_request <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence events and rate counter control
  // ----------------------------------------------------------------
  assign rs_done   = state == IMS_RS_SDA_LO && rate.expired;
  assign tx_eighth = state == IMS_TX_HIGH && rate.expired && bit_cnt == IMS_LAST_DATA;
  assign tx_done   = state == IMS_TX_HIGH && rate.expired && bit_cnt == IMS_ACK_SLOT;
  assign rx_done   = state == IMS_RX_HIGH && rate.expired && bit_cnt == IMS_LAST_DATA;
  assign ak_done   = state == IMS_AK_HIGH && rate.expired && !coll_now;
  assign coll_now  = (state == IMS_RS_SDA_HI && rate.expired && !sda_s)
                  || (state == IMS_RS_SCL_REL && scl_s && !sda_s)
                  || (state == IMS_RS_BOTH_HI && !scl_s)
                  || (state == IMS_AK_HIGH && ack_value && !sda_s);

  assign rate.ce     = ce_i;
  assign rate.reload = rate_reload_value;

  always_comb begin
    rate.load = 1'b0;
    rate.run  = 1'b0;
    case (state)
      IMS_IDLE: begin
        rate.load = buf_wr_ok || receive_request || ack_sequence_request;
      end
      IMS_RS_LOW: begin
        rate.load = !scl_s;
      end
      IMS_RS_SCL_REL, IMS_TX_REL, IMS_RX_REL, IMS_AK_REL: begin
        rate.load = scl_s;
      end
      default: begin
        rate.run = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state               <= IMS_IDLE;
      scl_low             <= 1'b0;
      sda_low             <= 1'b0;
      shift_reg           <= 8'h00;
      bit_cnt             <= 4'h0;
      ack_received_status <= 1'b0;
    end else if (ce_i) begin
      if (coll_now) begin
        state   <= IMS_IDLE;
        scl_low <= 1'b0;
        sda_low <= 1'b0;
      end else begin
        case (state)
          IMS_IDLE: begin
            bit_cnt <= 4'h0;
            if (buf_wr_ok) begin
              shift_reg <= pwdata_i[7:0];
              sda_low   <= !pwdata_i[7];
              scl_low   <= 1'b1;
              state     <= IMS_TX_LOW;
            end else if (restart_request) begin
              scl_low <= 1'b1;
              state   <= IMS_RS_LOW;
            end else if (receive_request) begin
              scl_low <= 1'b1;
              sda_low <= 1'b0;
              state   <= IMS_RX_LOW;
            end else if (ack_sequence_request) begin
              scl_low <= 1'b1;
              sda_low <= !ack_value;
              state   <= IMS_AK_LOW;
            end
          end
          IMS_RS_LOW: begin
            if (!scl_s) begin
              sda_low <= 1'b0;
              state   <= IMS_RS_SDA_HI;
            end
          end
          IMS_RS_SDA_HI: begin
            if (rate.expired) begin
              scl_low <= 1'b0;
              state   <= IMS_RS_SCL_REL;
            end
          end
          IMS_RS_SCL_REL: begin
            if (scl_s) begin
              state <= IMS_RS_BOTH_HI;
            end
          end
          IMS_RS_BOTH_HI: begin
            if (rate.expired) begin
              sda_low <= 1'b1;
              state   <= IMS_RS_SDA_LO;
            end
          end
          IMS_RS_SDA_LO: begin
            if (rate.expired) begin
              scl_low <= 1'b1;
              state   <= IMS_IDLE;
            end
          end
          IMS_TX_LOW, IMS_RX_LOW, IMS_AK_LOW: begin
            if (rate.expired) begin
              scl_low <= 1'b0;
              state   <= ims_state_e'(state + 4'h1);
            end
          end
          IMS_TX_REL: begin
            if (scl_s) begin
              if (bit_cnt == IMS_ACK_SLOT) begin
                ack_received_status <= sda_s;
              end
              state <= IMS_TX_HIGH;
            end
          end
          IMS_TX_HIGH: begin
            if (rate.expired) begin
              scl_low <= 1'b1;
              if (tx_done) begin
                state <= IMS_IDLE;
              end else begin
                bit_cnt   <= bit_cnt + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sda_low   <= tx_eighth ? 1'b0 : !shift_reg[6];
                state     <= IMS_TX_LOW;
              end
            end
          end
          IMS_RX_REL: begin
            if (scl_s) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              state     <= IMS_RX_HIGH;
            end
          end
          IMS_RX_HIGH: begin
            if (rate.expired) begin
              scl_low <= 1'b1;
              bit_cnt <= bit_cnt + 4'h1;
              state   <= rx_done ? IMS_IDLE : IMS_RX_LOW;
            end
          end
          IMS_AK_REL: begin
            if (scl_s) begin
              state <= IMS_AK_HIGH;
            end
          end
          IMS_AK_HIGH: begin
            if (rate.expired) begin
              scl_low <= 1'b1;
              state   <= IMS_IDLE;
            end
          end
          default: begin
            state <= IMS_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer and status flags
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      byte_buffer <= 8'h00;
      buffer_full <= 1'b0;
    end else if (ce_i) begin
      if (buf_wr_ok) begin
        byte_buffer <= pwdata_i[7:0];
      end else if (rx_done) begin
        byte_buffer <= shift_reg;
      end
      if (buf_wr_ok || rx_done) begin
        buffer_full <= 1'b1;
      end else if (tx_eighth || buf_rd || (coll_now && state != IMS_IDLE)) begin
        buffer_full <= 1'b0;
      end
    end
  end

  // Status flags clear by writing one; a hardware set in the same cycle wins.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_seen       <= 1'b0;
      port_irq_flag    <= 1'b0;
      write_collision  <= 1'b0;
      receive_overflow <= 1'b0;
      collision_flag   <= 1'b0;
    end else if (ce_i) begin
      if (start_pattern && state inside {IMS_RS_BOTH_HI, IMS_RS_SDA_LO}) begin
        start_seen <= 1'b1;
      end else if (stat_wr && pwdata_i[IMS_ST_START]) begin
        start_seen <= 1'b0;
      end
      if (rs_done || tx_done || rx_done || ak_done) begin
        port_irq_flag <= 1'b1;
      end else if (stat_wr && pwdata_i[IMS_ST_IRQ]) begin
        port_irq_flag <= 1'b0;
      end
      if (buf_wr && !idle) begin
        write_collision <= 1'b1;
      end else if (stat_wr && pwdata_i[IMS_ST_WRITE_COLLISION]) begin
        write_collision <= 1'b0;
      end
      if (rx_done && buffer_full && !buf_rd) begin
        receive_overflow <= 1'b1;
      end else if (stat_wr && pwdata_i[IMS_ST_OVF]) begin
        receive_overflow <= 1'b0;
      end
      if (coll_now) begin
        collision_flag <= 1'b1;
      end else if (stat_wr && pwdata_i[IMS_ST_BCOL]) begin
        collision_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  sequence rs_last_period;
    ce_i && state == IMS_RS_SDA_LO && rate.expired;
  endsequence

  sequence rs_left_held;
    state == IMS_IDLE && scl_low && sda_low && !restart_request && port_irq_flag;
  endsequence

  restart_gate_a: assert property (ce_i && ctrl_wr && pwdata_i[IMS_CTRL_RESTART]
      && !idle && !restart_request |=> !restart_request)
    else $error("restart request accepted while busy");
  rs_sda_release_a: assert property (state == IMS_RS_SDA_HI |-> scl_low && !sda_low)
    else $error("restart high period with wrong line drive");
  rs_both_high_a: assert property (state == IMS_RS_BOTH_HI |-> !scl_low && !sda_low)
    else $error("restart setup period with a line driven");
  rs_finish_a: assert property (rs_last_period |=> rs_left_held)
    else $error("restart did not finish holding both lines low");
  rs_coll_a: assert property (ce_i && state == IMS_RS_BOTH_HI && !scl_s
      |=> state == IMS_IDLE && collision_flag && !scl_low && !sda_low)
    else $error("restart collision not handled");
  write_collision_keep_a: assert property (ce_i && buf_wr && !idle
      |=> write_collision && $stable(byte_buffer))
    else $error("busy buffer write not refused");
  ack_capture_a: assert property (ce_i && state == IMS_TX_REL && scl_s && bit_cnt == IMS_ACK_SLOT
      |=> ack_received_status == $past(sda_s))
    else $error("acknowledge level not stored");
  tx_eighth_a: assert property (ce_i && tx_eighth |=> !sda_low && scl_low
      && bit_cnt == IMS_ACK_SLOT)
    else $error("SDA not released after eighth bit");
  rx_done_a: assert property (ce_i && rx_done |=> state == IMS_IDLE && buffer_full
      && port_irq_flag && scl_low && byte_buffer == $past(shift_reg))
    else $error("received byte not delivered");
  stretch_a: assert property (is_release(state) |-> !rate.run)
    else $error("rate counter ran while SCL released");
endmodule
`default_nettype wire

/* File: core/ims_pkg.sv */
// Constants, register map and state encoding for the byte sequencer.
package ims_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses on the register bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] IMS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] IMS_OFS_STATUS = 8'h04;
  localparam logic [7:0] IMS_OFS_BUFFER = 8'h08;
  localparam logic [7:0] IMS_OFS_RATE   = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned IMS_CTRL_RESTART = 0;
  localparam int unsigned IMS_CTRL_RECEIVE = 1;
  localparam int unsigned IMS_CTRL_ACKSEQ  = 2;
  localparam int unsigned IMS_CTRL_ACKVAL  = 3;

  localparam int unsigned IMS_ST_BF    = 0;
  localparam int unsigned IMS_ST_ACKRX = 1;
  localparam int unsigned IMS_ST_START = 2;
  localparam int unsigned IMS_ST_IRQ   = 3;
  localparam int unsigned IMS_ST_WRITE_COLLISION  = 4;
  localparam int unsigned IMS_ST_OVF   = 5;
  localparam int unsigned IMS_ST_BCOL  = 6;
  localparam int unsigned IMS_ST_IDLE  = 7;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  IMS_RATE_RESET = 8'h09;
  localparam logic [3:0]  IMS_LAST_DATA  = 4'h7;
  localparam logic [3:0]  IMS_ACK_SLOT   = 4'h8;
  localparam int unsigned IMS_SYNC_W     = 2;

  typedef enum logic [3:0] {
    IMS_IDLE       = 4'b0000,
    IMS_RS_LOW     = 4'b0001,
    IMS_RS_SDA_HI  = 4'b0010,
    IMS_RS_SCL_REL = 4'b0011,
    IMS_RS_BOTH_HI = 4'b0100,
    IMS_RS_SDA_LO  = 4'b0101,
    IMS_TX_LOW     = 4'b0110,
    IMS_TX_REL     = 4'b0111,
    IMS_TX_HIGH    = 4'b1000,
    IMS_RX_LOW     = 4'b1001,
    IMS_RX_REL     = 4'b1010,
    IMS_RX_HIGH    = 4'b1011,
    IMS_AK_LOW     = 4'b1100,
    IMS_AK_REL     = 4'b1101,
    IMS_AK_HIGH    = 4'b1110
  } ims_state_e;

endpackage

/* File: core/ims_rate_if.sv */
// Control and status signals between the sequencer and its rate counter.
`timescale 1ns/100ps
`default_nettype none
interface ims_rate_if;
  logic       ce;
  logic       load;
  logic       run;
  logic [7:0] reload;
  logic       expired;

  modport ctl (output ce, output load, output run, output reload, input expired);
  modport ctr (input ce, input load, input run, input reload, output expired);
endinterface
`default_nettype wire

/* File: core/ims_sync.sv */
// Two-stage synchroniser for the bus line inputs.
`timescale 1ns/100ps
`default_nettype none
module ims_sync
  import ims_pkg::*;
(
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  input  wire logic [IMS_SYNC_W-1:0] async_i,
  output logic      [IMS_SYNC_W-1:0] sync_o
);
  logic [IMS_SYNC_W-1:0] meta;

  for (genvar g = 0; g < IMS_SYNC_W; g++) begin : g_line
    // Idle bus lines float high, so both stages reset high.
    always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta[g]   <= 1'b1;
        sync_o[g] <= 1'b1;
      end else if (ce_i) begin
        meta[g]   <= async_i[g];
        sync_o[g] <= meta[g];
      end
    end
  end
endmodule
`default_nettype wire

/* File: core/ims_rate_ctr.sv */
// Reloadable down counter that paces each timed low and high bus period.
`timescale 1ns/100ps
`default_nettype none
module ims_rate_ctr (
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  ims_rate_if.ctr   rate
);
  logic [7:0] count;

  assign rate.expired = rate.run && (count == 8'h00);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 8'h00;
    end else if (rate.ce) begin
      if (rate.load || rate.expired) begin
        count <= rate.reload;
      end else if (rate.run) begin
        count <= count - 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/ims_slave.sv */
// Behavioural slave device on the two-wire bus.
`timescale 1ns/100ps
`default_nettype none
module ims_slave (
  input  wire logic       clr_i,
  input  wire logic       send_i,
  input  wire logic       ack_i,
  input  wire logic [7:0] data_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            pull_o = 1'b0,
  output logic      [7:0] got_o
);
  // ----------------------------------------------------------------
  // Bit framing
  // ----------------------------------------------------------------
  // The count of SCL falls since the last clear selects the bit slot.
  // The model only changes SDA while SCL is low.
  int f = 0;
  always @(posedge clr_i or negedge scl_i) begin
    if (clr_i) begin
      f = 0;
      pull_o = send_i && !data_i[7];
    end else begin
      f = f + 1;
      pull_o = send_i ? (f < 8 && !data_i[7-f]) : (f == 8 && ack_i);
    end
  end
  always @(posedge scl_i) begin
    if (f < 8) got_o[7-f] <= sda_i;
  end
endmodule
`default_nettype wire

/* File: verif/ims_top_bench.sv */
// Self-checking bench for the two-wire master byte sequencer.
`timescale 1ns/100ps
`default_nettype none
module i2c_master_byte_sequencer_bench;
  import ims_pkg::*;
  // ----------------------------------------------------------------
  // Signals, clock and instances
  // ----------------------------------------------------------------
  logic        core_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic        clr = 0, send = 0, ack = 0, pready, pslverr, err, pull;
  logic        scl_oe_n, sda_oe_n, scl_w, sda_w, scl_d, sda_d, hold = 0;
  logic [7:0]  paddr = 0, data = 0, got;
  logic [31:0] pwdata = 0, prdata, rd;
  int          errors = 0, compares = 0;
  // Both lines have pull-ups; any party may pull low, and hold plays a second master on SCL.
  assign scl_w = (scl_oe_n ? 1'b1 : scl_d) & ~hold;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_d) & ~pull;
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  ims_top i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(1'b1), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_d),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n));
  ims_slave i_slv (.clr_i(clr), .send_i(send), .ack_i(ack), .data_i(data), .scl_i(scl_w),
    .sda_i(sda_w), .pull_o(pull), .got_o(got));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wait_irq;
    do bus(1'b0, IMS_OFS_STATUS, 32'h0); while (rd[IMS_ST_IRQ] !== 1'b1);
  endtask
  task automatic slave(input logic s, input logic a, input logic [7:0] d);
    send = s;
    ack = a;
    data = d;
    clr = 1'b1;
    #1 clr = 1'b0;
  endtask
  task automatic complete_run;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, IMS_OFS_RATE, 32'h0);
    chk(rd, 32'h9, "rate reset");
    bus(1'b0, IMS_OFS_STATUS, 32'h0);
    chk(rd, 32'h80, "status reset");
    bus(1'b1, 8'h10, 32'h1);
    chk({31'h0, err}, 32'h1, "unmapped");
    bus(1'b1, IMS_OFS_RATE, 32'h3);
    $display("test registers done");
    bus(1'b1, IMS_OFS_CTRL, 32'h1);
    bus(1'b1, IMS_OFS_BUFFER, 32'h77);
    wait_irq;
    chk(rd & 32'hd5, 32'h94, "restart status");
    chk({30'h0, sda_oe_n, scl_oe_n}, 32'h0, "restart lines");
    bus(1'b1, IMS_OFS_STATUS, 32'h7c);
    $display("test restart done");
    for (int i = 0; i < 2; i++) begin
      logic [7:0] b;
      b = (i == 1) ? 8'h5a : 8'ha5;
      slave(1'b0, i == 0, 8'h0);
      bus(1'b1, IMS_OFS_BUFFER, {24'h0, b});
      bus(1'b0, IMS_OFS_STATUS, 32'h0);
      chk(rd & 32'h81, 32'h1, "buffer full");
      bus(1'b1, IMS_OFS_CTRL, 32'h3);
      bus(1'b1, IMS_OFS_BUFFER, 32'hff);
      wait_irq;
      chk({24'h0, got}, {24'h0, b}, "sent byte");
      chk(rd & 32'h93, {24'h0, 6'h24, i == 1, 1'b0}, "tx status");
      chk({30'h0, sda_oe_n, scl_oe_n}, 32'h2, "tx lines");
      bus(1'b0, IMS_OFS_CTRL, 32'h0);
      chk(rd & 32'h3, 32'h0, "busy requests");
      bus(1'b1, IMS_OFS_STATUS, 32'h7c);
    end
    $display("test transmit done");
    for (int i = 0; i < 2; i++) begin
      slave(1'b1, 1'b0, (i == 1) ? 8'hc3 : 8'h3c);
      bus(1'b1, IMS_OFS_CTRL, 32'h2);
      wait_irq;
      chk(rd & 32'ha1, {24'h0, 2'h2, i == 1, 5'h01}, "rx status");
      bus(1'b1, IMS_OFS_STATUS, 32'h7c);
      bus(1'b0, IMS_OFS_CTRL, 32'h0);
      chk(rd & 32'h2, 32'h0, "rx request");
    end
    bus(1'b0, IMS_OFS_BUFFER, 32'h0);
    chk(rd, 32'hc3, "rx byte");
    bus(1'b0, IMS_OFS_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0, "full cleared");
    $display("test receive done");
    bus(1'b1, IMS_OFS_CTRL, 32'hc);
    wait_irq;
    chk(rd & 32'hc0, 32'h80, "ack done");
    bus(1'b0, IMS_OFS_CTRL, 32'h0);
    chk({30'h0, rd[2], scl_oe_n}, 32'h0, "ack cleared");
    $display("test acknowledge done");
    bus(1'b1, IMS_OFS_CTRL, 32'h1);
    @(posedge scl_w);
    repeat (2) @(posedge core_clk_i);
    hold <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    hold <= 1'b0;
    bus(1'b0, IMS_OFS_STATUS, 32'h0);
    chk(rd & 32'hc0, 32'hc0, "restart collision");
    chk({30'h0, sda_oe_n, scl_oe_n}, 32'h3, "collision lines");
    bus(1'b0, IMS_OFS_CTRL, 32'h0);
    chk(rd & 32'h1, 32'h0, "collision request");
    $display("test collision done");
    complete_run;
  end
endmodule
`default_nettype wire
